// *** logic/hcr_config_regs.sv ***
// Command, identifier and first setup register of the hub, addresses 00h-07h.
// Assumes a serial slave engine on the same clock that issues one-cycle
// strobes only after a complete, valid byte write or byte read.
`timescale 1ns/1ps
`default_nettype none
`include "hcr_params.svh"

module hcr_config_regs
    import hcr_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    // Byte access from the serial slave engine.
    input  wire logic  write_strobe,
    input  wire logic  read_strobe,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] write_data,
    output logic [7:0] read_data,
    output logic       read_done,
    // Pins and neighbouring configuration.
    input  wire logic  local_power_detect_pin,
    input  wire logic  dynamic_switch_enable,
    // Serial slave control.
    output logic       slave_reset,
    output logic       slave_shutdown,
    // Hub core controls.
    output logic       upstream_attach,
    output logic       config_write_lock,
    output logic       power_source_select,
    output logic       indicator_present,
    output logic       fullspeed_only_select,
    output logic       per_port_translator_select,
    output logic       frame_end_packet_suppress,
    output logic [1:0] overload_sensing_mode,
    output logic       power_switching_mode,
    output logic [15:0] vendor_code,
    output logic [15:0] product_code,
    output logic [15:0] release_code
);

    // -------------------------------------------------------------------------
    // Declarations
    // -------------------------------------------------------------------------
    hcr_store_if        store ();       // Identifier byte store link.
    logic               power_pin_sync; // Local power pin after two flops.
    logic               soft_reset_reg; // Soft reset bit, high for one cycle.
    logic               lock_reg;       // Configuration write lock.
    logic               attach_reg;     // Upstream attach request.
    logic               shutdown_reg;   // Serial slave powered down.
    logic [7:0]         setup_reg;      // First setup byte.
    logic               power_self_reg; // Effective self-powered status.
    hcr_read_state_type rd_state_reg;   // Read pipeline state.
    logic [7:0]         rd_addr_reg;    // Address of the read in flight.
    logic [7:0]         read_data_reg;  // Answer byte.
    logic               read_done_reg;  // Answer valid pulse.
    logic               wr_take;        // Write accepted by the bank.
    logic               rd_take;        // Read accepted by the bank.
    logic               wr_cmd;         // Write to the command register.
    logic               wr_setup;       // Unlocked write to the setup byte.
    logic               wr_ident;       // Unlocked write to an identifier.

    // -------------------------------------------------------------------------
    // Address helpers
    // -------------------------------------------------------------------------

    // True for the six identifier byte addresses.
    function automatic logic is_ident(input logic [7:0] addr);
        is_ident = (addr >= `HCR_ADDR_IDENT_FIRST) && (addr <= `HCR_ADDR_IDENT_LAST);
    endfunction

    // Store index of an identifier address; low byte sits at the lower address.
    function automatic hcr_ident_idx_type ident_idx(input logic [7:0] addr);
        logic [7:0] diff;
        diff      = addr - `HCR_ADDR_IDENT_FIRST;
        ident_idx = diff[2:0];
    endfunction

    // True for addresses that the lock guards.
    function automatic logic is_locked_range(input logic [7:0] addr);
        is_locked_range = (addr >= `HCR_ADDR_IDENT_FIRST) && (addr <= `HCR_ADDR_LOCK_LAST);
    endfunction

    // -------------------------------------------------------------------------
    // Access decode
    // -------------------------------------------------------------------------

    // Once shut down the slave answers nothing, so strobes are dropped here too.
    // The attach bit closes the door one cycle earlier, so a strobe that
    // trails the attach write is never half served.
    // Only a completed valid transaction ever produces a strobe.
    assign wr_take  = write_strobe && !shutdown_reg && !attach_reg;
    assign rd_take  = read_strobe && !shutdown_reg && !attach_reg;
    assign wr_cmd   = wr_take && (reg_addr == `HCR_ADDR_CMD);
    // Locked writes are taken and acknowledged but store nothing.
    assign wr_setup = wr_take && (reg_addr == `HCR_ADDR_SETUP) && !lock_reg;
    assign wr_ident = wr_take && is_ident(reg_addr) && !(lock_reg && is_locked_range(reg_addr));

    // -------------------------------------------------------------------------
    // Input synchroniser and identifier store
    // -------------------------------------------------------------------------
    hcr_pin_sync u_power_sync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   (local_power_detect_pin),
        .pin_sync (power_pin_sync)
    );

    hcr_ident_store u_ident
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .port     (store.store)
    );

    assign store.wr_en   = wr_ident;
    assign store.wr_idx  = ident_idx(reg_addr);
    assign store.wr_data = write_data;
    assign store.clr     = soft_reset_reg;
    assign store.rd_idx  = ident_idx(reg_addr);

    // -------------------------------------------------------------------------
    // Command register
    // -------------------------------------------------------------------------

    // Soft reset lasts one cycle: the bit is cleared by the very reset it
    // starts. A new request in that same cycle wins and keeps it high.
    // Reserved bits 7:3 are not stored and read back as zero.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_reset_reg <= 1'b0;
        else if (wr_cmd && write_data[`HCR_CMD_SOFT_BIT])
            soft_reset_reg <= 1'b1;
        else
            soft_reset_reg <= 1'b0;
    end

    // The lock can only be set; nothing but the reset pin clears it, so the
    // soft reset leaves it alone.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            lock_reg <= 1'b0;
        else if (wr_cmd && write_data[`HCR_CMD_LOCK_BIT])
            lock_reg <= 1'b1;
    end

    // Attach is set-only too and tells the hub core to attach upstream.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            attach_reg <= 1'b0;
        else if (wr_cmd && write_data[`HCR_CMD_ATTACH_BIT])
            attach_reg <= 1'b1;
    end

    // The strobe arrives after the acknowledge, so the shutdown one cycle
    // later never cuts that acknowledge short. It lasts until the pin reset.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            shutdown_reg <= 1'b0;
        else if (attach_reg)
            shutdown_reg <= 1'b1;
    end

    // -------------------------------------------------------------------------
    // Setup byte
    // -------------------------------------------------------------------------

    // All eight bits are plain storage; bit 7 feeds the power source choice below, the rest are decoded downstream.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            setup_reg <= `HCR_RESET_BYTE;
        else if (soft_reset_reg)
            setup_reg <= `HCR_RESET_BYTE;
        else if (wr_setup)
            setup_reg <= write_data;
    end

    // With dynamic switching on, the synchronised pin decides, so the hub can
    // fall back to bus power and return when local power reappears.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_self_reg <= 1'b0;
        else if (dynamic_switch_enable)
            power_self_reg <= power_pin_sync;
        else
            power_self_reg <= setup_reg[`HCR_SETUP_PWR_BIT];
    end

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------

    // Two cycles for every read: the identifier store has a registered port
    // and the answer is registered again, so all addresses share one latency.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_state_reg <= HCR_RD_IDLE;
            rd_addr_reg  <= `HCR_RESET_BYTE;
        end
        else
        begin
            unique case (rd_state_reg)
                HCR_RD_IDLE:
                begin
                    if (rd_take)
                    begin
                        rd_state_reg <= HCR_RD_FETCH;
                        rd_addr_reg  <= reg_addr;
                    end
                end
                HCR_RD_FETCH:
                begin
                    rd_state_reg <= HCR_RD_IDLE;
                end
            endcase
        end
    end

    // Answer byte and its valid pulse; addresses above 07h belong elsewhere
    // and read as zero here.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_data_reg <= `HCR_RESET_BYTE;
            read_done_reg <= 1'b0;
        end
        else
        begin
            read_done_reg <= (rd_state_reg == HCR_RD_FETCH);
            if (rd_state_reg == HCR_RD_FETCH)
            begin
                if (rd_addr_reg == `HCR_ADDR_CMD)
                    read_data_reg <= {5'h00, soft_reset_reg, lock_reg, attach_reg};
                else if (is_ident(rd_addr_reg))
                    read_data_reg <= store.rd_data;
                else if (rd_addr_reg == `HCR_ADDR_SETUP)
                    read_data_reg <= setup_reg;
                else
                    read_data_reg <= `HCR_RESET_BYTE;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Outputs, all from flip-flops
    // -------------------------------------------------------------------------
    assign read_data                  = read_data_reg;
    assign read_done                  = read_done_reg;
    assign slave_reset                = soft_reset_reg;
    assign slave_shutdown             = shutdown_reg;
    assign upstream_attach            = attach_reg;
    assign config_write_lock          = lock_reg;
    assign power_source_select        = power_self_reg;
    assign indicator_present          = setup_reg[`HCR_SETUP_IND_BIT];
    assign fullspeed_only_select      = setup_reg[`HCR_SETUP_FS_BIT];
    assign per_port_translator_select = setup_reg[`HCR_SETUP_TT_BIT];
    assign frame_end_packet_suppress  = setup_reg[`HCR_SETUP_EOP_BIT];
    assign overload_sensing_mode      = setup_reg[`HCR_SETUP_SENSE_LSB +: 2];
    assign power_switching_mode       = setup_reg[`HCR_SETUP_SWITCH_BIT];
    assign vendor_code                = store.contents[15:0];
    assign product_code               = store.contents[31:16];
    assign release_code               = store.contents[47:32];

    // -------------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------------
    // All checks run on the core clock and sleep through the pin reset.
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    chk_lock_holds_setup: assert property (
        lock_reg && write_strobe && (reg_addr == `HCR_ADDR_SETUP) && !soft_reset_reg
        |=> $stable(setup_reg))
        else $error("Setup byte changed while locked.");

    chk_lock_sticky: assert property (
        lock_reg |=> lock_reg [*8])
        else $error("Write lock was cleared.");

    chk_attach_sticky: assert property (
        attach_reg |=> attach_reg)
        else $error("Attach bit was cleared.");

    chk_soft_self_clear: assert property (
        soft_reset_reg && !wr_cmd |=> !soft_reset_reg)
        else $error("Soft reset bit did not clear itself.");

    chk_soft_clears_setup: assert property (
        soft_reset_reg |=> (setup_reg == `HCR_RESET_BYTE) && (store.contents == 48'h0))
        else $error("Soft reset left configuration behind.");

    chk_attach_shutdown: assert property (
        $rose(attach_reg) |=> shutdown_reg ##1 !read_done [*2])
        else $error("Slave not shut down after attach.");

    chk_power_choice: assert property (
        ##1 power_self_reg == ($past(dynamic_switch_enable) ? $past(power_pin_sync)
                               : $past(setup_reg[`HCR_SETUP_PWR_BIT])))
        else $error("Power source status wrong.");

    chk_read_latency: assert property (
        rd_take && rd_state_reg == HCR_RD_IDLE |=> !read_done ##1 read_done)
        else $error("Read answer not two cycles later.");

    chk_fullspeed_write: assert property (
        wr_setup && !soft_reset_reg |=> fullspeed_only_select == $past(write_data[5]))
        else $error("Full-speed-only bit not stored.");

    // A refused identifier write leaves all six bytes alone.
    chk_lock_holds_ident: assert property (
        lock_reg && write_strobe && is_ident(reg_addr) && !soft_reset_reg
        |=> $stable(store.contents))
        else $error("Identifier changed while locked.");

    // Reserved command bits always read as zero.
    chk_cmd_reserved: assert property (
        read_done && (rd_addr_reg == `HCR_ADDR_CMD) |-> (read_data[7:3] == 5'h00))
        else $error("Reserved command bits read as one.");

    // Once shut down, a read strobe brings no answer.
    chk_shutdown_silent: assert property (
        shutdown_reg && read_strobe |-> ##2 !read_done)
        else $error("Read answered after shutdown.");

    cov_lock_write: cover property (lock_reg && write_strobe && reg_addr == `HCR_ADDR_SETUP);
    cov_soft_reset: cover property (soft_reset_reg ##1 read_done);
    cov_attach:     cover property ($rose(attach_reg) ##1 shutdown_reg);
    cov_dynamic:    cover property (dynamic_switch_enable && $changed(power_self_reg));

endmodule

`default_nettype wire

// *** common/hcr_params.svh ***
// Constants of the hub configuration and command register bank.
// Assumes it is included by its bare name from the package and the modules.
//
// What this block does
// - Soft reset restores setup and identifier defaults.
// - Soft reset bit clears itself.
// - Lock bit blocks writes to 01h-10h.
// - Lock and attach set once, pin-clear only.
// - Attach bit signals upstream attach.
// - Serial slave shuts down after attach write.
// - Identifiers are low byte, then high byte.
// - Power bit: zero bus, one self.
// - Dynamic switching uses local power pin instead.
// - Indicator bit reports LED indicators present.
// - Full-speed-only bit forbids high-speed attach.
// - Translator bit: shared or per port.
// - Suppress bit stops full-speed frame-end packet.
// - Sensing field: ganged, per port, none.
// - Switching bit: ganged or per port.
// - Every register resets to zero.
// - Only valid byte transactions touch registers.
// - Dynamic switching follows local power changes.
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define HCR_ADDR_CMD         8'h00
`define HCR_ADDR_IDENT_FIRST 8'h01
`define HCR_ADDR_IDENT_LAST  8'h06
`define HCR_ADDR_SETUP       8'h07
`define HCR_ADDR_LOCK_LAST   8'h10

// -----------------------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------------------
`define HCR_CMD_ATTACH_BIT   0
`define HCR_CMD_LOCK_BIT     1
`define HCR_CMD_SOFT_BIT     2
`define HCR_SETUP_SWITCH_BIT 0
`define HCR_SETUP_SENSE_LSB  1
`define HCR_SETUP_EOP_BIT    3
`define HCR_SETUP_TT_BIT     4
`define HCR_SETUP_FS_BIT     5
`define HCR_SETUP_IND_BIT    6
`define HCR_SETUP_PWR_BIT    7
`define HCR_RESET_BYTE       8'h00

`endif

// *** common/hcr_pkg.sv ***
// Types shared by the hub configuration register bank.
// Assumes the constants header sits beside it on the include path.
`include "hcr_params.svh"

package hcr_pkg;
    // Read pipeline: idle, then one cycle waiting on the store's read register.
    typedef enum logic {HCR_RD_IDLE, HCR_RD_FETCH} hcr_read_state_type;
    // Index into the six identifier bytes.
    typedef logic [2:0] hcr_ident_idx_type;
endpackage

// *** common/hcr_store_if.sv ***
// Connection between the register bank and its identifier byte store.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none

interface hcr_store_if;
    import hcr_pkg::*;
    logic                wr_en;    // Write one byte this cycle.
    hcr_ident_idx_type   wr_idx;   // Byte written.
    logic [7:0]          wr_data;  // Value written.
    logic                clr;      // Return every byte to its default.
    hcr_ident_idx_type   rd_idx;   // Byte read.
    logic [7:0]          rd_data;  // Registered read value.
    logic [47:0]         contents; // All six bytes, lowest address lowest.

    modport store (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data, contents);
    modport ctl   (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data, contents);
endinterface

`default_nettype wire

// *** logic/hcr_ident_store.sv ***
// Six-byte store for the vendor, product and release codes.
// Assumes the controller never writes and clears in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "hcr_params.svh"

module hcr_ident_store
    import hcr_pkg::*;
(
    input  wire logic   core_clk,
    input  wire logic   rst_n,
    hcr_store_if.store  port
);
    logic [7:0] mem_reg [0:5]; // Identifier bytes.
    logic [7:0] rd_data_reg;   // Read data come out of a register.

    // -------------------------------------------------------------------------
    // Storage. A clear wins over a write so a soft reset always lands.
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 6; i++) mem_reg[i] <= `HCR_RESET_BYTE;
        end
        else if (port.clr)
        begin
            for (int i = 0; i < 6; i++) mem_reg[i] <= `HCR_RESET_BYTE;
        end
        else if (port.wr_en)
        begin
            mem_reg[port.wr_idx] <= port.wr_data;
        end
    end

    // -------------------------------------------------------------------------
    // Registered read port.
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_reg <= `HCR_RESET_BYTE;
        else
            rd_data_reg <= mem_reg[port.rd_idx];
    end

    assign port.rd_data  = rd_data_reg;
    assign port.contents = {mem_reg[5], mem_reg[4], mem_reg[3],
                            mem_reg[2], mem_reg[1], mem_reg[0]};
endmodule

`default_nettype wire

// *** logic/hcr_pin_sync.sv ***
// Two-stage synchroniser for one asynchronous pin.
// Assumes the pin may change at any time relative to the core clock.
`timescale 1ns/1ps
`default_nettype none

module hcr_pin_sync
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic pin_in,
    output logic      pin_sync
);
    logic meta_reg;   // First stage, read only by the second.
    logic stable_reg; // Second stage, safe for logic.

    // -------------------------------------------------------------------------
    // Both stages in one process; nothing else looks at the first.
    // -------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg   <= 1'b0;
            stable_reg <= 1'b0;
        end
        else
        begin
            meta_reg   <= pin_in;
            stable_reg <= meta_reg;
        end
    end

    assign pin_sync = stable_reg;
endmodule

`default_nettype wire

// *** test/hcr_slave_model.sv ***
// Behavioural serial slave engine that hands finished byte accesses to the bank.
// Assumes it shares the core clock and drives only at falling edges.
`timescale 1ns/1ps
`default_nettype none

module hcr_slave_model
(
    input  wire logic       core_clk,
    input  wire logic [7:0] read_data,
    input  wire logic       read_done,
    output logic            write_strobe,
    output logic            read_strobe,
    output logic [7:0]      reg_addr,
    output logic [7:0]      write_data
);
    // Idle values; released lines show a changed value, never the last one.
    initial
    begin
        write_strobe = 1'b0;
        read_strobe  = 1'b0;
        reg_addr     = 8'h5a;
        write_data   = 8'ha5;
    end

    // One complete write byte transaction, strobed once after its acknowledge.
    task automatic put(input logic [7:0] addr, input logic [7:0] data);
        @(negedge core_clk);
        write_strobe = 1'b1;
        reg_addr     = addr;
        write_data   = data;
        @(negedge core_clk);
        write_strobe = 1'b0;
        reg_addr     = ~addr;
        write_data   = ~data;
    endtask

    // One read byte transaction; the answer is awaited for a bounded three edges.
    task automatic get(input logic [7:0] addr, output logic [7:0] data, output logic seen);
        @(negedge core_clk);
        read_strobe = 1'b1;
        reg_addr    = addr;
        @(negedge core_clk);
        read_strobe = 1'b0;
        reg_addr    = ~addr;
        seen        = 1'b0;
        data        = 8'h00;
        repeat (3)
        begin
            @(posedge core_clk);
            #1;
            if (read_done === 1'b1)
            begin
                seen = 1'b1;
                data = read_data;
            end
        end
    endtask
endmodule

`default_nettype wire

// *** test/hub_config_command_regs_bench.sv ***
// Self-checking bench for the hub configuration register bank.
// Assumes the slave engine model beside the bank on one 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module hub_config_command_regs_bench;
    // -------------------------------------------------------------------------
    // Signals and instances
    // -------------------------------------------------------------------------
    logic        core_clk, rst_n, write_strobe, read_strobe, read_done, rd_seen;
    logic        local_power_detect_pin, dynamic_switch_enable, slave_reset;
    logic        slave_shutdown, upstream_attach, config_write_lock, power_source_select;
    logic        indicator_present, fullspeed_only_select, per_port_translator_select;
    logic        frame_end_packet_suppress, power_switching_mode;
    logic [1:0]  overload_sensing_mode;
    logic [7:0]  reg_addr, write_data, read_data, setup_out, rd_val;
    logic [15:0] vendor_code, product_code, release_code;
    int          miscompares, checked;

    // Setup outputs gathered back into register bit order.
    assign setup_out = {power_source_select, indicator_present, fullspeed_only_select,
        per_port_translator_select, frame_end_packet_suppress, overload_sensing_mode,
        power_switching_mode};

    hcr_slave_model i_host (.core_clk, .read_data, .read_done, .write_strobe,
        .read_strobe, .reg_addr, .write_data);
    hcr_config_regs i_dut (.core_clk, .rst_n, .write_strobe, .read_strobe, .reg_addr,
        .write_data, .read_data, .read_done, .local_power_detect_pin,
        .dynamic_switch_enable, .slave_reset, .slave_shutdown, .upstream_attach,
        .config_write_lock, .power_source_select, .indicator_present,
        .fullspeed_only_select, .per_port_translator_select, .frame_end_packet_suppress,
        .overload_sensing_mode, .power_switching_mode, .vendor_code, .product_code,
        .release_code);

    // Free-running core clock.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // -------------------------------------------------------------------------
    // Shared checks
    // -------------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Reads one byte; a missing answer fails as well as a wrong value.
    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        i_host.get(addr, rd_val, rd_seen);
        chk({7'h00, rd_seen, rd_val}, {8'h01, exp});
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    // The command, shutdown and setup outputs and every byte, including one past the bank, are zero.
    task automatic t_reset;
        chk({upstream_attach, config_write_lock, slave_shutdown, slave_reset, setup_out}, 16'h0000);
        for (int a = 0; a < 9; a++)
            rchk(8'(a), 8'h00);
    endtask

    // Identifier bytes pair low then high into the three codes.
    task automatic t_ident;
        for (int a = 1; a < 7; a++)
            i_host.put(8'(a), 8'(8'h11 * a));
        chk(vendor_code, 16'h2211);
        chk(product_code, 16'h4433);
        chk(release_code, 16'h6655);
        rchk(8'h06, 8'h66);
    endtask

    // Each setup bit alone reaches its own output; with dynamic switching the power output follows the pin.
    task automatic t_setup;
        for (int b = 0; b < 8; b++)
        begin
            i_host.put(8'h07, 8'h01 << b);
            @(negedge core_clk);
            chk(setup_out, 16'(8'h01 << b));
            rchk(8'h07, 8'h01 << b);
        end
        i_host.put(8'h07, 8'h00);
        dynamic_switch_enable = 1'b1;
        local_power_detect_pin = 1'b1;
        repeat (4) @(negedge core_clk);
        chk(power_source_select, 16'h0001);
        local_power_detect_pin = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(power_source_select, 16'h0000);
        dynamic_switch_enable = 1'b0;
    endtask

    // Soft reset pulses the slave reset, clears storage and clears itself.
    task automatic t_soft;
        i_host.put(8'h07, 8'h7b);
        i_host.put(8'h00, 8'h04);
        chk(slave_reset, 16'h0001);
        @(negedge core_clk);
        chk({7'h00, slave_reset, setup_out}, 16'h0000);
        chk(vendor_code, 16'h0000);
        rchk(8'h00, 8'h00);
    endtask

    // Lock stops later writes silently and cannot be cleared by software.
    task automatic t_lock;
        i_host.put(8'h01, 8'h3c);
        i_host.put(8'h00, 8'h02);
        i_host.put(8'h01, 8'hc3);
        i_host.put(8'h07, 8'h01);
        chk({8'h00, setup_out}, 16'h0000);
        chk(vendor_code, 16'h003c);
        rchk(8'h01, 8'h3c);
        i_host.put(8'h00, 8'h00);
        chk(config_write_lock, 16'h0001);
    endtask

    // Attach raises the upstream request, then the slave side stops answering.
    task automatic t_attach;
        i_host.put(8'h00, 8'h01);
        chk(upstream_attach, 16'h0001);
        @(negedge core_clk);
        chk(slave_shutdown, 16'h0001);
        i_host.get(8'h00, rd_val, rd_seen);
        chk(rd_seen, 16'h0000);
        @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        chk({upstream_attach, config_write_lock, slave_shutdown}, 16'h0000);
    endtask

    // -------------------------------------------------------------------------
    // Main sequence and watchdog
    // -------------------------------------------------------------------------
    initial
    begin
        miscompares = 0;
        checked = 0;
        rst_n = 1'b0;
        local_power_detect_pin = 1'b0;
        dynamic_switch_enable = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset;
        t_ident;
        t_setup;
        t_soft;
        t_lock;
        t_attach;
        results;
    end

    // The tests need well under 1000 cycles; 5000 cycles means a hang.
    initial
    begin
        #100000;
        miscompares++;
        results;
    end
endmodule

`default_nettype wire
